/* core/fb_ctrl_pkg.sv */
// Package of the stepper feedback-mode controller: register map, fields, resets, modes.
// Assumes a 100 MHz ref_clk and an APB register bus with 32-bit data.
package fb_ctrl_pkg;
  // Register byte addresses.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_RUN    = 8'h04;
  localparam logic [7:0] A_HOLD   = 8'h08;
  localparam logic [7:0] A_HDLY   = 8'h0c;
  localparam logic [7:0] A_TQ     = 8'h10;
  localparam logic [7:0] A_TS     = 8'h14;
  localparam logic [7:0] A_LIM    = 8'h18;
  localparam logic [7:0] A_MKV0   = 8'h1c;
  localparam logic [7:0] A_MKV1   = 8'h20;
  localparam logic [7:0] A_PLIM   = 8'h24;
  localparam logic [7:0] A_VWIN   = 8'h28;
  localparam logic [7:0] A_VTHR   = 8'h2c;
  localparam logic [7:0] A_STAT   = 8'h30;
  localparam logic [7:0] A_MASK   = 8'h34;
  localparam logic [7:0] A_LL     = 8'h38;
  localparam logic [7:0] A_LT     = 8'h3c;
  localparam logic [7:0] A_STATE  = 8'h40;
  // Control register fields.
  localparam int C_MODE  = 0;
  localparam int C_MK_EN = 2;
  localparam int C_MK_SEL = 3;
  localparam int C_LIM_EN = 4;
  localparam int C_CLR   = 5;
  localparam int C_SCALE = 8;
  // Event bits of the status and mask registers.
  localparam int NEV      = 4;
  localparam int S_LOCK   = 0;
  localparam int S_REJ    = 1;
  localparam int S_MKDONE = 2;
  localparam int S_VWIN   = 3;
  // Motor resolution, the two-full-step synchronism bound, register reset values and the variable-current gain.
  localparam logic [15:0] USTEPS    = 16'h0010;
  localparam logic [15:0] LIM_RST   = 16'h0020;
  localparam logic [7:0]  RUN_RST   = 8'h50;
  localparam logic [7:0]  HOLD_RST  = 8'h19;
  localparam logic [15:0] HDLY_RST  = 16'h03e8;
  localparam logic [15:0] MKV_RST   = 16'h0100;
  localparam logic [15:0] LT_RST    = 16'hffff;
  localparam logic [15:0] VAR_GAIN  = 16'h0004;
  // Feedback-control modes.
  typedef enum logic [1:0] {
    M_BYPASS = 2'b00,
    M_FIXED  = 2'b01,
    M_VAR    = 2'b10,
    M_TORQUE = 2'b11
  } fb_mode_type;
  // Motion operation modes set by the network side.
  typedef enum logic [2:0] {
    OP_PP   = 3'b001,
    OP_PV   = 3'b011,
    OP_PT   = 3'b100,
    OP_HOME = 3'b110,
    OP_CSP  = 3'b111
  } op_mode_type;
endpackage

/* core/leadlag_if.sv */
// Interface carrying step events into the lead/lag accumulator and its count back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface leadlag_if;
  logic              cmd_fwd;
  logic              cmd_rev;
  logic              enc_fwd;
  logic              enc_rev;
  logic              clr;
  logic signed [15:0] count;
  modport ctl (output cmd_fwd, output cmd_rev, output enc_fwd, output enc_rev, output clr, input count);
  modport acc (input cmd_fwd, input cmd_rev, input enc_fwd, input enc_rev, input clr, output count);
endinterface
`default_nettype wire

/* core/leadlag_acc.sv */
// Signed lead/lag accumulator: commanded steps count up, encoder steps count down.
// Assumes a synchronised reset and single-cycle step pulses.
`timescale 1ns/1ns
`default_nettype none
module leadlag_acc
  import fb_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  leadlag_if.acc   ll
);
  typedef struct packed {
    logic signed [15:0] cnt;
  } acc_type;
  acc_type s_q;
  acc_type s_d;

  // Net change per cycle; clearing after a make-up move overrides counting.
  always_comb begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + 16'(ll.cmd_fwd) - 16'(ll.cmd_rev) - 16'(ll.enc_fwd) + 16'(ll.enc_rev);
    if (ll.clr) begin
      s_d.cnt = '0;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign ll.count = s_q.cnt;
endmodule
`default_nettype wire

/* core/fb_ctrl.sv */
// Feedback-mode motion controller of an integrated stepper drive with APB registers.
// Assumes step commands and motion mode come from logic on ref_clk; encoder pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Lead/lag is kept within two full steps either way in feedback modes.
// - Four modes: bypass, fixed current, variable current, torque.
// - A mode change is accepted only while no move runs.
// - Bypass forwards commanded steps straight to the step output.
// - Bypass uses only run and hold current levels.
// - Feedback modes compare encoder steps with commanded steps to hold bounds.
// - Commanded minus actual position accumulates in the lead/lag register.
// - After a move, make-up reinserts stored pulses at one of two velocities.
// - Fixed-current mode takes run and hold current settings.
// - Variable mode scales current with load, never above run current.
// - Torque mode holds torque percent and limits speed to torque speed.
// - Profile torque operation forces torque feedback mode.
// - Without encoder: bypass only, fixed run and hold current.
// - Current depends on run, hold, hold delay and fixed or variable control.
// - Profile position limits the target, then scales it to increments.
// - Profile velocity checks a window and the actual velocity threshold.
// - Cyclic synchronous position takes master targets each cycle directly.
// - Bound or timeout exceeded in feedback mode disables bridge, flags lock.
module fb_ctrl
  import fb_ctrl_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  input  wire logic               cmd_step,
  input  wire logic               cmd_dir,
  input  wire logic               move_active,
  input  wire logic [2:0]         op_mode,
  input  wire logic signed [31:0] target_pos,
  input  wire logic               target_valid,
  input  wire logic signed [15:0] vel_demand,
  input  wire logic signed [15:0] vel_actual,
  input  wire logic               enc_step,
  input  wire logic               enc_dir,
  input  wire logic               enc_fitted,
  output var  logic               step_out,
  output var  logic               dir_out,
  output var  logic [7:0]         phase_current,
  output var  logic               bridge_enable,
  output var  logic               locked_rotor_err,
  output var  logic signed [31:0] position_demand,
  output var  logic               vel_in_window,
  output var  logic               vel_over_thresh,
  output var  logic               irq
);
  typedef struct packed {
    logic [2:0]     es;
    logic [2:0]     ed;
    logic [2:0]     ef;
    logic           est;
    logic           fit;
    fb_mode_type    mode;
    logic [15:0]    ctrl;
    logic [7:0]     run;
    logic [7:0]     hold;
    logic [15:0]    hdly;
    logic [7:0]     tq;
    logic [15:0]    ts;
    logic [15:0]    lim;
    logic [15:0]    mkv0;
    logic [15:0]    mkv1;
    logic [31:0]    plim;
    logic [15:0]    vwin;
    logic [15:0]    vthr;
    logic [15:0]    lt;
    logic [NEV-1:0] sts;
    logic [NEV-1:0] msk;
    logic [31:0]    rdata;
    logic           rdy;
    logic           err;
    logic [15:0]    hcnt;
    logic [15:0]    div;
    logic           mk;
    logic [15:0]    mk_left;
    logic           mk_dir;
    logic           mv;
    logic [15:0]    lcnt;
    logic           bridge;
    logic           lock;
    logic           step;
    logic           dir;
    logic [7:0]     cur;
    logic [31:0]    pdem;
    logic           vok;
    logic           vhi;
    logic           irq;
  } st_type;

  st_type s_q;
  st_type s_d;
  logic [1:0] rsync_q;
  logic       rst_core_n;
  leadlag_if  ll_if();

  // Reset release through two flip-flops.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsync_q <= 2'b00;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_core_n = rsync_q[1];

  leadlag_acc u_acc (
    .ref_clk (ref_clk),
    .rst_n   (rst_core_n),
    .ce      (ce),
    .ll      (ll_if)
  );

  // Next state of the whole controller.
  always_comb begin
    logic           acc;
    logic           done;
    shortint        llv;
    logic [15:0]    mag;
    logic           fb;
    logic           moving;
    logic           fwd_ok;
    logic           tick;
    logic           enc_edge;
    logic [15:0]    vmag;
    logic [15:0]    amag;
    logic [NEV-1:0] set;
    logic [NEV-1:0] rclr;
    int             t;
    logic [23:0]    vcur;
    fb_mode_type    eff;
    acc = 1'b0;
    done = 1'b0;
    llv = '0;
    mag = '0;
    fb = 1'b0;
    moving = 1'b0;
    fwd_ok = 1'b0;
    tick = 1'b0;
    enc_edge = 1'b0;
    vmag = '0;
    amag = '0;
    set = '0;
    rclr = '0;
    t = '0;
    vcur = '0;
    eff = M_BYPASS;
    s_d = s_q;
    ll_if.cmd_fwd = 1'b0;
    ll_if.cmd_rev = 1'b0;
    ll_if.enc_fwd = 1'b0;
    ll_if.enc_rev = 1'b0;
    ll_if.clr = 1'b0;

    // Pins pass three flops; a change counts once stages two and three agree.
    s_d.es = {s_q.es[1:0], enc_step};
    s_d.ed = {s_q.ed[1:0], enc_dir};
    s_d.ef = {s_q.ef[1:0], enc_fitted};
    if (s_q.es[2] == s_q.es[1]) begin
      s_d.est = s_q.es[2];
    end
    if (s_q.ef[2] == s_q.ef[1]) begin
      s_d.fit = s_q.ef[2];
    end
    enc_edge = s_d.est & ~s_q.est;

    // Effective mode: no encoder means bypass, profile torque forces torque mode.
    if (!s_q.fit) begin
      eff = M_BYPASS;
    end else if (op_mode == OP_PT) begin
      eff = M_TORQUE;
    end else begin
      eff = s_q.mode;
    end
    fb = (eff != M_BYPASS) && s_q.bridge;
    llv = ll_if.count;
    mag = llv[15] ? 16'(-llv) : 16'(llv);
    moving = move_active | s_q.mk | (eff == M_TORQUE);

    // Encoder steps reduce the lead/lag when feedback is active.
    if (fb && enc_edge) begin
      ll_if.enc_fwd = s_q.ed[2];
      ll_if.enc_rev = ~s_q.ed[2];
    end

    // Step generation per mode; feedback holds steps back at the bound.
    fwd_ok = mag < s_q.lim;
    s_d.step = 1'b0;
    s_d.div = s_q.div + 16'h0001;
    if (eff == M_BYPASS) begin
      s_d.step = cmd_step & s_q.bridge;
      s_d.dir = cmd_dir;
    end else if (s_q.mk) begin
      if (s_q.div >= (s_q.ctrl[C_MK_SEL] ? s_q.mkv1 : s_q.mkv0)) begin
        tick = 1'b1;
      end
      if (tick) begin
        s_d.div = '0;
        s_d.step = s_q.bridge;
        s_d.dir = s_q.mk_dir;
        s_d.mk_left = s_q.mk_left - 16'h0001;
        done = (s_q.mk_left == 16'h0001);
      end
    end else if (eff == M_TORQUE) begin
      if (move_active && s_q.div >= s_q.ts) begin
        s_d.div = '0;
        if (fwd_ok && s_q.bridge) begin
          s_d.step = 1'b1;
          s_d.dir = cmd_dir;
          ll_if.cmd_fwd = cmd_dir;
          ll_if.cmd_rev = ~cmd_dir;
        end
      end
    end else if (cmd_step && fwd_ok && s_q.bridge) begin
      s_d.step = 1'b1;
      s_d.dir = cmd_dir;
      ll_if.cmd_fwd = cmd_dir;
      ll_if.cmd_rev = ~cmd_dir;
    end

    // Make-up starts at the end of a move and clears the register when done.
    s_d.mv = move_active;
    if (!s_q.mk && s_q.mv && !move_active && fb && s_q.ctrl[C_MK_EN] && mag != 16'h0000 && eff != M_TORQUE) begin
      s_d.mk = 1'b1;
      s_d.mk_left = mag;
      s_d.mk_dir = ~llv[15];
      s_d.div = '0;
    end
    if (done || (s_q.mk && !fb)) begin
      s_d.mk = 1'b0;
      ll_if.clr = 1'b1;
      set[S_MKDONE] = done;
    end

    // Locked rotor: bound exceeded or no encoder motion within the timeout.
    if (fb && move_active && mag != 16'h0000 && !enc_edge) begin
      s_d.lcnt = (s_q.lcnt == 16'hffff) ? s_q.lcnt : s_q.lcnt + 16'h0001;
    end else begin
      s_d.lcnt = '0;
    end
    if (fb && (mag > s_q.lim || s_q.lcnt >= s_q.lt)) begin
      s_d.bridge = 1'b0;
      s_d.lock = 1'b1;
      set[S_LOCK] = 1'b1;
    end

    // Phase current from run, hold, hold delay and the current-control style.
    if (moving) begin
      s_d.hcnt = s_q.hdly;
    end else if (s_q.hcnt != 16'h0000) begin
      s_d.hcnt = s_q.hcnt - 16'h0001;
    end
    vcur = 24'(s_q.hold) + 24'(mag) * 24'(VAR_GAIN);
    if (!s_q.bridge) begin
      s_d.cur = '0;
    end else if (eff == M_TORQUE) begin
      s_d.cur = s_q.tq;
    end else if (!(moving || s_q.hcnt != 16'h0000)) begin
      s_d.cur = s_q.hold;
    end else if (eff == M_VAR) begin
      s_d.cur = (vcur > 24'(s_q.run)) ? s_q.run : vcur[7:0];
    end else begin
      s_d.cur = s_q.run;
    end

    // Position demand: optional limit, then normalise to increments; cyclic targets too.
    if (target_valid && (op_mode == OP_PP || op_mode == OP_CSP)) begin
      t = target_pos;
      if (op_mode == OP_PP && s_q.ctrl[C_LIM_EN]) begin
        if (t > $signed(s_q.plim)) begin
          t = $signed(s_q.plim);
        end else if (t < -$signed(s_q.plim)) begin
          t = -$signed(s_q.plim);
        end
      end
      s_d.pdem = t <<< s_q.ctrl[C_SCALE +: 4];
    end

    // Velocity window and threshold monitoring in profile velocity mode.
    vmag = (vel_demand - vel_actual) < 0 ? 16'(vel_actual - vel_demand) : 16'(vel_demand - vel_actual);
    amag = vel_actual[15] ? 16'(-vel_actual) : 16'(vel_actual);
    if (op_mode == OP_PV) begin
      s_d.vok = vmag <= s_q.vwin;
      s_d.vhi = amag > s_q.vthr;
      set[S_VWIN] = s_q.vok & ~s_d.vok;
    end

    // APB slave: access answered on its second cycle, write and read-clear on completion.
    acc = psel & penable;
    s_d.rdy = acc & ~s_q.rdy;
    s_d.err = 1'b0;
    if (acc && !s_q.rdy) begin
      s_d.err = 1'b0;
      unique case (paddr)
        A_CTRL:  s_d.rdata = {16'h0000, s_q.ctrl[15:2], s_q.mode};
        A_RUN:   s_d.rdata = 32'(s_q.run);
        A_HOLD:  s_d.rdata = 32'(s_q.hold);
        A_HDLY:  s_d.rdata = 32'(s_q.hdly);
        A_TQ:    s_d.rdata = 32'(s_q.tq);
        A_TS:    s_d.rdata = 32'(s_q.ts);
        A_LIM:   s_d.rdata = 32'(s_q.lim);
        A_MKV0:  s_d.rdata = 32'(s_q.mkv0);
        A_MKV1:  s_d.rdata = 32'(s_q.mkv1);
        A_PLIM:  s_d.rdata = s_q.plim;
        A_VWIN:  s_d.rdata = 32'(s_q.vwin);
        A_VTHR:  s_d.rdata = 32'(s_q.vthr);
        A_STAT:  s_d.rdata = 32'(s_q.sts);
        A_MASK:  s_d.rdata = 32'(s_q.msk);
        A_LL:    s_d.rdata = 32'(llv);
        A_LT:    s_d.rdata = 32'(s_q.lt);
        A_STATE: s_d.rdata = {24'h000000, s_q.fit, s_q.mk, s_q.lock, s_q.bridge, 2'b00, eff};
        default: begin
          s_d.rdata = '0;
          s_d.err = 1'b1;
        end
      endcase
    end
    if (acc && s_q.rdy && !pwrite && paddr == A_STAT) begin
      rclr = s_q.sts;
    end
    if (acc && s_q.rdy && pwrite) begin
      unique case (paddr)
        A_CTRL: begin
          s_d.ctrl = pwdata[15:0];
          if (pwdata[C_CLR]) begin
            s_d.lock = 1'b0;
            s_d.bridge = 1'b1;
            s_d.lcnt = '0;
          end
          if (move_active || s_q.mk) begin
            set[S_REJ] = (pwdata[C_MODE +: 2] != s_q.mode);
          end else begin
            s_d.mode = fb_mode_type'(pwdata[C_MODE +: 2]);
          end
        end
        A_RUN:   s_d.run = pwdata[7:0];
        A_HOLD:  s_d.hold = pwdata[7:0];
        A_HDLY:  s_d.hdly = pwdata[15:0];
        A_TQ:    s_d.tq = pwdata[7:0];
        A_TS:    s_d.ts = pwdata[15:0];
        A_LIM:   s_d.lim = pwdata[15:0];
        A_MKV0:  s_d.mkv0 = pwdata[15:0];
        A_MKV1:  s_d.mkv1 = pwdata[15:0];
        A_PLIM:  s_d.plim = pwdata;
        A_VWIN:  s_d.vwin = pwdata[15:0];
        A_VTHR:  s_d.vthr = pwdata[15:0];
        A_MASK:  s_d.msk = pwdata[NEV-1:0];
        A_LT:    s_d.lt = pwdata[15:0];
        default: s_d.msk = s_q.msk;
      endcase
    end

    // Sticky events: a new event wins over a read clear in the same cycle.
    s_d.sts = (s_q.sts & ~rclr) | set;
    s_d.irq = |(s_d.sts & s_q.msk);
  end

  // Single state register, frozen while the clock enable is low.
  always_ff @(posedge ref_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      s_q <= '0;
      s_q.mode <= M_BYPASS;
      s_q.run <= RUN_RST;
      s_q.hold <= HOLD_RST;
      s_q.hdly <= HDLY_RST;
      s_q.lim <= LIM_RST;
      s_q.mkv0 <= MKV_RST;
      s_q.mkv1 <= MKV_RST;
      s_q.lt <= LT_RST;
      s_q.bridge <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign prdata = s_q.rdata;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err;
  assign step_out = s_q.step;
  assign dir_out = s_q.dir;
  assign phase_current = s_q.cur;
  assign bridge_enable = s_q.bridge;
  assign locked_rotor_err = s_q.lock;
  assign position_demand = s_q.pdem;
  assign vel_in_window = s_q.vok;
  assign vel_over_thresh = s_q.vhi;
  assign irq = s_q.irq;
endmodule
`default_nettype wire

/* dv/fb_ctrl_assertions.sv */
// Checker of the feedback-mode controller, watching its top ports only.
// Assumes ce stays high, so every taken APB access answers on time.
`timescale 1ns/1ns
`default_nettype none
module fb_ctrl_checker
  import fb_ctrl_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cmd_step,
  input wire logic        cmd_dir,
  input wire logic        move_active,
  input wire logic [2:0]  op_mode,
  input wire logic        step_out,
  input wire logic        dir_out,
  input wire logic        bridge_enable,
  input wire logic        locked_rotor_err,
  input wire logic [31:0] position_demand,
  input wire logic        vel_in_window,
  input wire logic        vel_over_thresh
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // A taken access is answered by one single-cycle ready pulse.
  sequence apb_take; psel && penable && !pready; endsequence
  sequence apb_done; pready ##1 !pready; endsequence
  a_apb_answer: assert property (apb_take |=> apb_done) else $error("ready late or too long");
  a_ready_access: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("ready outside an access");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  // A commanded step during a move keeps its direction.
  a_step_dir: assert property (step_out && $past(cmd_step) && $past(move_active) |-> dir_out == $past(cmd_dir))
    else $error("step direction wrong");
  // A locked rotor keeps the power stage off until a clearing write.
  a_lock_bridge: assert property (locked_rotor_err |-> !bridge_enable) else $error("bridge on at lock");
  a_lock_sticky: assert property (locked_rotor_err && !(psel && penable && pwrite) |=> locked_rotor_err)
    else $error("lock dropped by itself");
  a_vel_hold: assert property (op_mode != OP_PV |=> $stable({vel_in_window, vel_over_thresh}))
    else $error("velocity flags moved outside velocity mode");
  a_pos_hold: assert property (!(op_mode inside {OP_PP, OP_CSP}) |=> $stable(position_demand))
    else $error("position demand moved");
endmodule
`default_nettype wire

/* dv/net_master.sv */
// Network master model: frames moves and issues step pulses.
// Assumes its tasks start right after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module net_master
  import fb_ctrl_pkg::*;
(
  input  wire logic       ref_clk,
  output var  logic       cmd_step,
  output var  logic       cmd_dir,
  output var  logic       move_active,
  output var  logic [2:0] op_mode
);
  // Idle: no move, profile position.
  initial begin
    cmd_step = 1'b0;
    cmd_dir = 1'b0;
    move_active = 1'b0;
    op_mode = OP_PP;
  end
  // Selects the motion operation mode between moves.
  task automatic set_op(input op_mode_type m);
    op_mode <= m;
  endtask
  // Runs n steps gap+1 cycles apart after 2 + lead cycles; gap is nonzero.
  task automatic move(input int n, input logic dir, input int gap, input int lead);
    cmd_dir <= dir;
    move_active <= 1'b1;
    repeat (2 + lead) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      cmd_step <= 1'b1;
      @(posedge ref_clk);
      cmd_step <= 1'b0;
      repeat (gap) @(posedge ref_clk);
    end
    move_active <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench of the feedback-mode controller.
// Assumes the checker and master model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench
  import fb_ctrl_pkg::*;
;
  localparam logic [7:0]  RA [7] = '{A_RUN, A_HOLD, A_HDLY, A_LIM, A_MKV0, A_MKV1, A_LT};
  localparam logic [31:0] RV [7] = '{32'(RUN_RST), 32'(HOLD_RST), 32'(HDLY_RST), 32'(LIM_RST),
                                     32'(MKV_RST), 32'(MKV_RST), 32'(LT_RST)};
  logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, target_valid = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, target_pos = 32'h0;
  logic [15:0] vel_demand = 16'h0, vel_actual = 16'h0;
  logic        enc_step = 1'b0, enc_dir = 1'b0, enc_fitted = 1'b1, echo = 1'b1;
  logic [1:0]  ep = 2'b00;
  logic [31:0] prdata, d, position_demand;
  logic        pready, pslverr, e, cmd_step, cmd_dir, move_active, step_out, dir_out;
  logic        bridge_enable, locked_rotor_err, vel_in_window, vel_over_thresh, irq;
  logic [2:0]  op_mode;
  logic [7:0]  phase_current;
  int          skip = 0, base = 0, n_steps = 0, n_fail = 0, compares = 0;
  always #5 ref_clk = ~ref_clk;
  fb_ctrl u_fb_ctrl (.ref_clk, .rst_n, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cmd_step, .cmd_dir, .move_active, .op_mode, .target_pos(target_pos), .target_valid,
    .vel_demand(vel_demand), .vel_actual(vel_actual), .enc_step, .enc_dir, .enc_fitted, .step_out, .dir_out,
    .phase_current, .bridge_enable, .locked_rotor_err, .position_demand(position_demand), .vel_in_window,
    .vel_over_thresh, .irq);
  net_master u_net_master (.ref_clk, .cmd_step, .cmd_dir, .move_active, .op_mode);
  // Motor model: echoes each step as a two-cycle encoder pulse unless it slips.
  always @(posedge ref_clk) begin
    enc_dir <= dir_out;
    ep <= {ep[0], step_out && echo && (skip == 0 || (n_steps - base) % skip != skip - 1)};
    enc_step <= |ep;
    if (step_out) begin
      n_steps <= n_steps + 1;
    end
  end
  function automatic logic [1:0] eff_mode(input logic fitted, input logic [1:0] req);
    return fitted ? req : 2'b00;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer into d and e, then one idle cycle.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) n_fail++;
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Polls status until the event shows.
  task automatic wait_stat(input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0);
      k++;
    end while (d[b] !== 1'b1 && k < 100);
  endtask
  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    n_fail++;
    wrap_up();
  end
  initial begin
    int n, k0;
    logic dr;
    void'($urandom(32'hc03e));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    // Reset values, strap, unmapped places.
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, RA[i], 32'h0);
      chk(d, RV[i]);
    end
    apb(1'b0, A_STATE, 32'h0);
    chk(32'(d[7]), 32'h1);
    apb(1'b0, 8'h44, 32'h0);
    chk(d, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, 8'h48, 32'hffffffff);
    chk(32'(e), 32'h1);
    // Modes accepted while idle.
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, A_CTRL, 32'(m));
      apb(1'b0, A_STATE, 32'h0);
      chk(32'(d[1:0]), 32'(eff_mode(1'b1, 2'(m))));
    end
    // Mode change refused in a move.
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b1, A_HDLY, 32'd20);
    fork
      u_net_master.move(8, 1'b1, 6, 0);
      begin
        repeat (6) @(posedge ref_clk);
        apb(1'b1, A_CTRL, 32'h2);
      end
    join
    apb(1'b0, A_STATE, 32'h0);
    chk(32'(d[1:0]), 32'h1);
    apb(1'b0, A_STAT, 32'h0);
    chk(32'(d[S_REJ]), 32'h1);
    // Bypass steps, run then hold current.
    n = 4 + $urandom % 20;
    dr = 1'($urandom % 2);
    apb(1'b1, A_CTRL, 32'h0);
    k0 = n_steps;
    u_net_master.move(n, dr, 6, 0);
    chk(32'(n_steps - k0), 32'(n));
    chk(32'(dir_out), 32'(dr));
    chk(32'(phase_current), 32'(RUN_RST));
    repeat (40) @(posedge ref_clk);
    chk(32'(phase_current), 32'(HOLD_RST));
    // Slipping motor: make-up restores steps.
    n = 4 * (2 + $urandom % 5);
    apb(1'b1, A_MKV0, 32'h3);
    apb(1'b1, A_CTRL, 32'h5);
    base = n_steps;
    skip = 4;
    k0 = n_steps;
    u_net_master.move(n, 1'b1, 8, 0);
    echo <= 1'b0;
    wait_stat(S_MKDONE);
    chk(32'(d[S_MKDONE]), 32'h1);
    chk(32'(n_steps - k0), 32'(n + n / skip));
    apb(1'b0, A_LL, 32'h0);
    chk(d, 32'h0);
    // Stalled motor: bound, cap, make-up.
    apb(1'b1, A_CTRL, 32'h6);
    k0 = n_steps;
    fork
      u_net_master.move(40, 1'b1, 4, 0);
      begin
        repeat (180) @(posedge ref_clk);
        chk(32'(phase_current), 32'(RUN_RST));
      end
    join
    chk(32'(n_steps - k0), 32'(LIM_RST));
    wait_stat(S_MKDONE);
    chk(32'(n_steps - k0), 32'(2 * LIM_RST));
    // Lock by timeout, interrupt, clear.
    apb(1'b1, A_LT, 32'd30);
    apb(1'b1, A_MASK, 32'h0);
    apb(1'b1, A_CTRL, 32'h1);
    u_net_master.move(4, 1'b1, 20, 0);
    chk(32'(locked_rotor_err), 32'h1);
    chk(32'(bridge_enable), 32'h0);
    chk(32'(irq), 32'h0);
    apb(1'b1, A_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h1);
    apb(1'b0, A_STAT, 32'h0);
    chk(32'(d[S_LOCK]), 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h0);
    apb(1'b1, A_CTRL, 32'h21);
    repeat (2) @(posedge ref_clk);
    chk(32'({locked_rotor_err, bridge_enable}), 32'h1);
    // Profile torque: mode, current, speed.
    apb(1'b1, A_LT, 32'hffff);
    apb(1'b1, A_TQ, 32'h33);
    apb(1'b1, A_TS, 32'd9);
    apb(1'b1, A_CTRL, 32'h0);
    echo <= 1'b1;
    skip = 0;
    u_net_master.set_op(OP_PT);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, A_STATE, 32'h0);
    chk(32'(d[1:0]), 32'h3);
    k0 = n_steps;
    fork
      u_net_master.move(0, 1'b1, 1, 100);
      begin
        repeat (50) @(posedge ref_clk);
        chk(32'(phase_current), 32'h33);
      end
    join
    chk(32'(n_steps - k0 <= 11), 32'h1);
    // Position target scaled.
    u_net_master.set_op(OP_PP);
    apb(1'b1, A_CTRL, 32'h200);
    target_pos <= 32'($urandom % 1000);
    target_valid <= 1'b1;
    @(posedge ref_clk);
    target_valid <= 1'b0;
    for (int k = 0; k < 20 && position_demand !== target_pos <<< 2; k++) @(posedge ref_clk);
    chk(position_demand, target_pos <<< 2);
    // Velocity window and threshold.
    apb(1'b1, A_VWIN, 32'h10);
    apb(1'b1, A_VTHR, 32'h40);
    u_net_master.set_op(OP_PV);
    vel_demand <= 16'h50;
    vel_actual <= 16'h48;
    repeat (3) @(posedge ref_clk);
    chk(32'({vel_in_window, vel_over_thresh}), 32'h3);
    vel_actual <= 16'h20;
    repeat (3) @(posedge ref_clk);
    chk(32'({vel_in_window, vel_over_thresh}), 32'h0);
    // No encoder: bypass only.
    enc_fitted <= 1'b0;
    repeat (10) @(posedge ref_clk);
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b0, A_STATE, 32'h0);
    chk(32'(d[1:0]), 32'(eff_mode(enc_fitted, 2'b01)));
    wrap_up();
  end
endmodule
bind fb_ctrl fb_ctrl_checker u_fb_ctrl_checker (.ref_clk, .rst_n, .psel, .penable, .pwrite, .prdata, .pready,
  .pslverr, .cmd_step, .cmd_dir, .move_active, .op_mode, .step_out, .dir_out, .bridge_enable,
  .locked_rotor_err, .position_demand(position_demand), .vel_in_window, .vel_over_thresh);
`default_nettype wire
